/* File: core/bwdt_core.sv */
// Board watchdog: one byte-wide control/status register on APB,
// a 10 s interval timer, and NMI / board reset / system reset outputs.
// Assumes an APB master on mclk_i and an asynchronous config switch pin.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`include "bwdt_map.svh"

module bwdt_core #(
  parameter logic [`BWDT_CNT_W-1:0] TIMEOUT_CYCLES =
    `BWDT_CNT_W'(`BWDT_TIMEOUT_CYC)
) (
  // clock, reset, enable
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  // apb slave
  input  wire bwdt_pkg::bwdt_apb_req_t apb_req_i,
  output bwdt_pkg::bwdt_apb_rsp_t      apb_rsp_o,
  // board pins
  input  wire logic                   cfg_switch_i,
  output logic                        nmi_o,
  output logic                        board_reset_o,
  output logic                        sys_reset_n_o,
  output logic                        wdt_enabled_o
);

  import bwdt_pkg::*;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // a pattern is usable only when its two bits differ
  function automatic logic pat_ok(input logic [1:0] p);
    pat_ok = p[1] ^ p[0];
  endfunction

  function automatic logic is_ctrl(input logic [`BWDT_ADDR_W-1:0] a);
    is_ctrl = (a == `BWDT_REG_CTRL_ADDR);
  endfunction

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic                        sw_meta_r;
  logic                        sw_sync_r;
  logic                        pready_r;
  logic                        pslverr_r;
  logic [`BWDT_DATA_W-1:0]     prdata_r;
  logic                        sysrst_en_r;
  logic                        swen_r;
  logic                        status_r;
  logic                        action_r;
  logic [1:0]                  pat_r;
  bwdt_state_t                 state_r;
  bwdt_state_t                 state_nxt;
  logic                        nmi_r;
  logic                        board_rst_r;
  logic                        sys_rst_n_r;
  logic [`BWDT_RSTPULSE_W-1:0] pulse_cnt_r;
  logic                        access;
  logic                        fire;
  logic                        wr_fire;
  logic                        rd_fire;
  logic [7:0]                  wbyte;
  logic [1:0]                  wpat;
  logic                        wr_en_bit;
  logic                        do_enable;
  logic                        do_restart;
  logic                        do_disable;
  logic                        tmr_start;
  logic                        tmr_stop;
  logic                        tmr_expire;
  logic                        tmr_running;
  logic                        wdt_reset;
  logic [7:0]                  rd_byte;

  // ------------------------------------------------------------------
  // switch synchroniser
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_meta_r <= 1'b0;
      sw_sync_r <= 1'b0;
    end else if (ce_i) begin
      sw_meta_r <= cfg_switch_i;
      sw_sync_r <= sw_meta_r;
    end
  end

  // ------------------------------------------------------------------
  // apb handshake
  // ------------------------------------------------------------------
  // one wait state keeps pready and prdata straight from flops
  assign access  = apb_req_i.psel & apb_req_i.penable;
  assign fire    = access & pready_r;
  assign wr_fire = fire & apb_req_i.pwrite & is_ctrl(apb_req_i.paddr)
                   & apb_req_i.pstrb[0];
  assign rd_fire = access & ~pready_r & ~apb_req_i.pwrite;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce_i) begin
      if (fire) begin
        pready_r  <= 1'b0;
        pslverr_r <= 1'b0;
      end else if (access) begin
        pready_r  <= 1'b1;
        pslverr_r <= ~is_ctrl(apb_req_i.paddr);
      end
    end
  end

  always_comb begin
    rd_byte                   = 8'h00;
    rd_byte[`BWDT_BIT_SYSRST] = sysrst_en_r;
    rd_byte[`BWDT_BIT_SWEN]   = swen_r;
    rd_byte[`BWDT_BIT_SWITCH] = sw_sync_r;
    rd_byte[`BWDT_BIT_STATUS] = status_r;
    rd_byte[`BWDT_BIT_ACTION] = action_r;
    rd_byte[`BWDT_PAT_HI:`BWDT_PAT_LO] = pat_r;
  end

  // unmapped reads return zero along with the error flag
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_r <= `BWDT_ZERO_DATA;
    end else if (ce_i) begin
      if (rd_fire && is_ctrl(apb_req_i.paddr)) begin
        prdata_r <= {24'h00_0000, rd_byte};
      end else if (rd_fire) begin
        prdata_r <= `BWDT_ZERO_DATA;
      end
    end
  end

  // ------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------
  assign wbyte     = apb_req_i.pwdata[7:0];
  assign wpat      = wbyte[`BWDT_PAT_HI:`BWDT_PAT_LO];
  assign wr_en_bit = wbyte[`BWDT_BIT_SWEN];

  // enabling is locked out while the switch is set
  assign do_enable  = wr_fire & ~swen_r & wr_en_bit & pat_ok(wpat)
                      & ~sw_sync_r;
  // a repeated or non-complementary pattern does not restart the timer
  assign do_restart = wr_fire & swen_r & wr_en_bit & pat_ok(wpat)
                      & (wpat == ~pat_r);
  assign do_disable = (wr_fire & ~wr_en_bit) | (swen_r & sw_sync_r);

  // board-reset action takes the watchdog down with the board
  assign wdt_reset  = tmr_expire & action_r;

  // ------------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BWDT_ST_OFF: begin
        if (do_enable) begin
          state_nxt = BWDT_ST_RUN;
        end
      end
      BWDT_ST_RUN: begin
        if (do_disable || wdt_reset) begin
          state_nxt = BWDT_ST_OFF;
        end else if (tmr_expire) begin
          state_nxt = BWDT_ST_EXPIRED;
        end
      end
      BWDT_ST_EXPIRED: begin
        if (do_disable) begin
          state_nxt = BWDT_ST_OFF;
        end else if (do_restart) begin
          state_nxt = BWDT_ST_RUN;
        end
      end
      default: begin
        state_nxt = BWDT_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= BWDT_ST_OFF;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sysrst_en_r <= `BWDT_RST_SYSRST;
      action_r    <= `BWDT_RST_ACTION;
    end else if (ce_i && wr_fire) begin
      sysrst_en_r <= wbyte[`BWDT_BIT_SYSRST];
      action_r    <= wbyte[`BWDT_BIT_ACTION];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      swen_r <= `BWDT_RST_SWEN;
    end else if (ce_i) begin
      if (do_disable || wdt_reset) begin
        swen_r <= 1'b0;
      end else if (do_enable) begin
        swen_r <= 1'b1;
      end
    end
  end

  // reference pattern for the next restart comparison
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pat_r <= `BWDT_RST_PAT;
    end else if (ce_i) begin
      if (do_enable || do_restart) begin
        pat_r <= wpat;
      end
    end
  end

  // timeout wins over a restart in the same cycle; set again only by a
  // valid restart or by the reset input rst_i
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      status_r <= `BWDT_RST_STATUS;
    end else if (ce_i) begin
      if (tmr_expire) begin
        status_r <= 1'b0;
      end else if (do_restart) begin
        status_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // interval timer
  // ------------------------------------------------------------------
  assign tmr_start = do_enable | do_restart;
  assign tmr_stop  = do_disable | wdt_reset;

  bwdt_timer #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
  ) u_timer (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .start_i   (tmr_start),
    .stop_i    (tmr_stop),
    .expire_o  (tmr_expire),
    .running_o (tmr_running)
  );

  // ------------------------------------------------------------------
  // timeout actions
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      nmi_r <= 1'b0;
    end else if (ce_i) begin
      nmi_r <= tmr_expire & ~action_r;
    end
  end

  // reset outputs are stretched so downstream logic sees a real pulse
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_cnt_r <= '0;
      board_rst_r <= 1'b0;
      sys_rst_n_r <= 1'b1;
    end else if (ce_i) begin
      if (tmr_expire && (action_r || sysrst_en_r)) begin
        pulse_cnt_r <= `BWDT_RSTPULSE_CYC;
        board_rst_r <= action_r;
        sys_rst_n_r <= ~sysrst_en_r;
      end else if (pulse_cnt_r != '0) begin
        pulse_cnt_r <= pulse_cnt_r - `BWDT_RSTPULSE_W'(1);
      end else begin
        board_rst_r <= 1'b0;
        sys_rst_n_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_enabled_o <= 1'b0;
    end else if (ce_i) begin
      wdt_enabled_o <= (state_nxt != BWDT_ST_OFF);
    end
  end

  assign nmi_o             = nmi_r;
  assign board_reset_o     = board_rst_r;
  assign sys_reset_n_o     = sys_rst_n_r;
  // one driver for the whole response carrier
  assign apb_rsp_o         = '{pready:  pready_r,
                               pslverr: pslverr_r,
                               prdata:  prdata_r};

  // tmr_running mirrors the state machine; kept for the expiry check
  // only through state, so it is intentionally not an output
  logic unused_ok;
  assign unused_ok = tmr_running;

endmodule

/* File: core/bwdt_map.svh */
// Named offsets, field positions, reset values and timing for the
// board watchdog. Definitions only; included by the package and the core.
`ifndef BWDT_MAP_SVH
`define BWDT_MAP_SVH

// ------------------------------------------------------------------
// bus geometry
// ------------------------------------------------------------------
`define BWDT_ADDR_W        12
`define BWDT_DATA_W        32
`define BWDT_REG_CTRL_ADDR 12'h214

// ------------------------------------------------------------------
// control and status fields
// ------------------------------------------------------------------
`define BWDT_BIT_SYSRST    6
`define BWDT_BIT_SWEN      5
`define BWDT_BIT_SWITCH    4
`define BWDT_BIT_STATUS    3
`define BWDT_BIT_ACTION    2
`define BWDT_PAT_HI        1
`define BWDT_PAT_LO        0

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define BWDT_RST_SYSRST    1'h0
`define BWDT_RST_SWEN      1'h0
`define BWDT_RST_STATUS    1'h1
`define BWDT_RST_ACTION    1'h0
`define BWDT_RST_PAT       2'h0
`define BWDT_ZERO_DATA     32'h0000_0000

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define BWDT_CLK_HZ        25000000
`define BWDT_TIMEOUT_S     10
`define BWDT_TIMEOUT_CYC   (`BWDT_TIMEOUT_S * `BWDT_CLK_HZ)
`define BWDT_CNT_W         28
`define BWDT_RSTPULSE_CYC  5'h10
`define BWDT_RSTPULSE_W    5

`endif

/* File: core/bwdt_pkg.sv */
// Types shared by the board watchdog core and its testbench.
// Assumes bwdt_map.svh is on the include path.
`include "bwdt_map.svh"

package bwdt_pkg;

  // ----------------------------------------------------------------
  // bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [`BWDT_ADDR_W-1:0]   paddr;
    logic [`BWDT_DATA_W-1:0]   pwdata;
    logic [3:0]                pstrb;
  } bwdt_apb_req_t;

  typedef struct packed {
    logic                      pready;
    logic                      pslverr;
    logic [`BWDT_DATA_W-1:0]   prdata;
  } bwdt_apb_rsp_t;

  // ----------------------------------------------------------------
  // timeout actions and state encoding
  // ----------------------------------------------------------------
  typedef struct packed {
    logic nmi;
    logic board_reset;
    logic sys_reset_n;
  } bwdt_action_t;

  typedef enum logic [1:0] {
    BWDT_ST_OFF     = 2'b00,
    BWDT_ST_RUN     = 2'b01,
    BWDT_ST_EXPIRED = 2'b10
  } bwdt_state_t;

endpackage

/* File: core/bwdt_timer.sv */
// Interval down-counter of the board watchdog.
// Assumes start_i and stop_i are single-cycle strobes on mclk_i.
`timescale 1ns/1ns
`include "bwdt_map.svh"

module bwdt_timer #(
  parameter logic [`BWDT_CNT_W-1:0] TIMEOUT_CYCLES =
    `BWDT_CNT_W'(`BWDT_TIMEOUT_CYC)
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // control
  input  wire logic start_i,
  input  wire logic stop_i,
  // status
  output logic      expire_o,
  output logic      running_o
);

  logic [`BWDT_CNT_W-1:0] cnt_r;

  // ------------------------------------------------------------------
  // counter
  // ------------------------------------------------------------------
  // start wins over stop so a restart is never swallowed
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r     <= '0;
      running_o <= 1'b0;
      expire_o  <= 1'b0;
    end else if (ce_i) begin
      expire_o <= 1'b0;
      if (start_i) begin
        cnt_r     <= TIMEOUT_CYCLES - `BWDT_CNT_W'(1);
        running_o <= 1'b1;
      end else if (stop_i) begin
        running_o <= 1'b0;
      end else if (running_o) begin
        if (cnt_r == '0) begin
          expire_o  <= 1'b1;
          running_o <= 1'b0;
        end else begin
          cnt_r <= cnt_r - `BWDT_CNT_W'(1);
        end
      end
    end
  end

endmodule

/* File: tb/bwdt_core_chk.sv */
// Assertions on the board watchdog core ports.
// Assumes one clock mclk_i and the async reset rst_i.
`timescale 1ns/1ns
`include "bwdt_map.svh"

module bwdt_core_chk #(
  parameter logic [`BWDT_CNT_W-1:0] TIMEOUT_CYCLES = 28'h0000064
) (
  // clock and reset
  input wire logic                    mclk_i,
  input wire logic                    rst_i,
  input wire logic                    ce_i,
  // apb
  input wire bwdt_pkg::bwdt_apb_req_t apb_req_i,
  input wire bwdt_pkg::bwdt_apb_rsp_t apb_rsp_o,
  // board pins
  input wire logic                    cfg_switch_i,
  input wire logic                    nmi_o,
  input wire logic                    board_reset_o,
  input wire logic                    sys_reset_n_o,
  input wire logic                    wdt_enabled_o
);
  import bwdt_pkg::*;
  logic wr_done;
  // completed write to the control register
  assign wr_done = apb_req_i.psel && apb_req_i.penable
    && apb_rsp_o.pready && apb_req_i.pwrite && apb_req_i.pstrb[0]
    && (apb_req_i.paddr == `BWDT_REG_CTRL_ADDR);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  nmi_pulse_a: assert property (nmi_o |=> !nmi_o)
    else $error("nmi longer than one cycle");
  nmi_only_a: assert property (nmi_o |-> !board_reset_o)
    else $error("nmi together with board reset");
  brst_hold_a: assert property (
    $rose(board_reset_o) |=> board_reset_o[*8])
    else $error("board reset too short");
  brst_off_a: assert property (
    $rose(board_reset_o) |-> ##[0:1] !wdt_enabled_o)
    else $error("watchdog still on after board reset");
  sysrst_src_a: assert property (
    $fell(sys_reset_n_o) |-> (nmi_o || board_reset_o))
    else $error("system reset without timeout");
  en_reset_a: assert property ($fell(rst_i) |-> !wdt_enabled_o)
    else $error("enabled after reset");
  wr_disable_a: assert property (
    wr_done && !apb_req_i.pwdata[5] |=> !wdt_enabled_o)
    else $error("enable bit clear did not disable");
  en_cause_a: assert property ($rose(wdt_enabled_o) |->
    $past(wr_done && apb_req_i.pwdata[5] && ^apb_req_i.pwdata[1:0]))
    else $error("enabled without valid enable write");
endmodule

bind bwdt_core bwdt_core_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .apb_req_i(apb_req_i),
  .apb_rsp_o(apb_rsp_o), .cfg_switch_i(cfg_switch_i), .nmi_o(nmi_o),
  .board_reset_o(board_reset_o), .sys_reset_n_o(sys_reset_n_o),
  .wdt_enabled_o(wdt_enabled_o));

/* File: tb/board_watchdog_timer_test.sv */
// Self-checking bench for the board watchdog core.
// Assumes bwdt_pkg compiled first; interval shortened to 100 cycles.
`timescale 1ns/1ns

module board_watchdog_timer_test;
  import bwdt_pkg::*;
  localparam int TOI = 100;
  logic          mclk_i, rst_i, ce_i, cfg_switch_i;
  bwdt_apb_req_t req;
  bwdt_apb_rsp_t rsp;
  logic          nmi, brst, srst_n, en;
  logic [31:0]   seed;
  int            bad_count, checks_done, cyc, n_nmi, n_brst, n_srst;
  int            m_en, m_ref, m_st, m_act, m_sys, m_sw, k, t0, n;

  bwdt_core #(.TIMEOUT_CYCLES(28'h0000064)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .apb_req_i(req),
    .apb_rsp_o(rsp), .cfg_switch_i(cfg_switch_i), .nmi_o(nmi),
    .board_reset_o(brst), .sys_reset_n_o(srst_n), .wdt_enabled_o(en));

  initial begin
    mclk_i = 0;
    forever #20 mclk_i = ~mclk_i;
  end

  // event counters, cycles high or low
  // non-blocking so readers at the same edge see the pre-edge count
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (nmi === 1'b1) n_nmi <= n_nmi + 1;
    if (brst === 1'b1) n_brst <= n_brst + 1;
    if (srst_n === 1'b0) n_srst <= n_srst + 1;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task close_out();
    $display("counts bad %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp,
           input string m);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [3:0] s, output logic [31:0] rd, output logic er);
    int i;
    @(posedge mclk_i);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    req.pstrb <= s;
    @(posedge mclk_i);
    req.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk_i);
      if (rsp.pready === 1'b1) break;
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (i == 20) begin
      bad_count++;
      $display("BAD %0t no pready", $time);
      close_out();
    end
  endtask

  // write the control byte and step the model
  task wr(input logic [7:0] v);
    logic [31:0] r, d;
    logic        e;
    int          p;
    r = rnd();
    apb(1'b1, 12'h214, {r[31:8], v}, 4'hF, d, e);
    p = v[1:0];
    m_sys = v[6];
    m_act = v[2];
    if (!v[5]) m_en = 0;
    else if (m_en == 0) begin
      if (m_sw == 0 && (p == 1 || p == 2)) begin
        m_en = 1;
        m_ref = p;
      end
    end else if ((p == 1 || p == 2) && p == 3 - m_ref) begin
      m_ref = p;
      m_st = 1;
    end
  endtask

  task rd_chk(input logic [31:0] mk);
    logic [31:0] d, x;
    logic        e;
    x = 32'(m_sys*64 + m_en*32 + m_sw*16 + m_st*8 + m_act*4 + m_ref);
    apb(1'b0, 12'h214, 32'h0, 4'h0, d, e);
    chk({31'h0, e}, 32'h0, "read error flag");
    chk(d & mk, x & mk, "register value");
    chk({31'h0, en}, m_en, "enabled pin");
  endtask

  task wait_ev(output int c);
    for (c = 1; c < 3 * TOI; c++) begin
      @(posedge mclk_i);
      if (nmi === 1'b1 || brst === 1'b1) return;
    end
    bad_count++;
    $display("BAD %0t no timeout", $time);
    close_out();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic        e;
    req = '0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    cfg_switch_i = 1'b0;
    seed = 32'hFCEDE420;
    {m_en, m_ref, m_act, m_sys, m_sw} = '0;
    m_st = 1;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rd_chk(32'hFFFFFFFF);
    apb(1'b0, 12'h218, 32'h0, 4'h0, d, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(d, 32'h0, "unmapped data");
    apb(1'b1, 12'h218, 32'h21, 4'hF, d, e);
    rd_chk(32'hFFFFFFFF);
    $display("test reset and map done");

    cfg_switch_i <= 1'b1;
    m_sw = 1;
    repeat (3) @(posedge mclk_i);
    wr(8'h21);
    rd_chk(32'hFFFFFFFF);
    cfg_switch_i <= 1'b0;
    m_sw = 0;
    repeat (3) @(posedge mclk_i);
    wr(8'h20);
    wr(8'h23);
    apb(1'b1, 12'h214, 32'h21, 4'h0, d, e);
    rd_chk(32'hFFFFFFFF);
    wr(8'h21);
    rd_chk(32'hFFFFFFFF);
    $display("test enable done");

    for (k = 0; k < 6; k++) begin
      repeat (TOI / 2 + rnd() % 10) @(posedge mclk_i);
      wr(k[0] ? 8'h23 : 8'h21);
      wr(8'(32 + 3 - m_ref));
    end
    // interval is measured from the last valid restart
    t0 = cyc;
    rd_chk(32'hFFFFFFFF);
    chk(n_nmi + n_brst, 0, "keepalive");
    $display("test restart done");

    repeat (TOI / 2) @(posedge mclk_i);
    wr(8'(32 + m_ref));
    wait_ev(n);
    n = cyc - t0;
    chk((n >= TOI - 2 && n <= TOI + 3), 1, "interval");
    m_st = 0;
    repeat (20) @(posedge mclk_i);
    chk(n_nmi, 1, "nmi count");
    chk(n_brst + n_srst, 0, "no resets");
    rd_chk(32'hFFFFFFFF);
    wr(8'(32 + 3 - m_ref));
    rd_chk(32'hFFFFFFFF);
    $display("test nmi timeout done");

    wr(8'(96 + 3 - m_ref));
    wait_ev(n);
    m_st = 0;
    repeat (20) @(posedge mclk_i);
    chk(n_srst, 17, "system reset");
    wr(8'(36 + 3 - m_ref));
    wait_ev(n);
    m_st = 0;
    m_en = 0;
    repeat (20) @(posedge mclk_i);
    chk(n_brst, 17, "board reset");
    chk(n_srst, 17, "no system reset");
    rd_chk(32'h38);
    wr(8'h22);
    rd_chk(32'hFFFFFFFF);
    $display("test reset actions done");

    n = n_nmi;
    wr(8'h00);
    repeat (TOI + 20) @(posedge mclk_i);
    chk(n_nmi + n_brst, n + 17, "disabled");
    rd_chk(32'hFFFFFFFF);
    $display("test disable done");

    // switch raised while enabled takes the watchdog down
    wr(8'h21);
    cfg_switch_i <= 1'b1;
    m_sw = 1;
    m_en = 0;
    repeat (3) @(posedge mclk_i);
    rd_chk(32'hFFFFFFFF);
    $display("test switch lockout done");
    close_out();
  end
endmodule
